// >>> tb_tracking_buck_supervisor.sv
/*
  Testbench for the supervisor: APB master, sense stimulus, fault cases.
  Assumes the companion model supplies enable and the tracked rail.
*/
`timescale 1ns/1ps
module tb_tracking_buck_supervisor
  import tbs_pkg::*;
;
  localparam logic [3:0] S_OFF   = 4'h1;
  localparam logic [3:0] S_RAMP  = 4'h2;
  localparam logic [3:0] S_RUN   = 4'h4;
  localparam logic [3:0] S_FAULT = 4'h8;

  logic        sys_clk, rst, go, enable_pin, hs_gate, ls_gate;
  logic        psel, penable, pwrite, pready, pslverr;
  logic        hs_q = 1'b0;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [9:0]  vout, vtrack, iout, vref_target;
  logic [7:0]  temp;
  tbs_sense_s  sense;
  tbs_flags_s  flags;
  int          err_count, n_compared;

  assign sense = {vout, vtrack, iout, temp};

  tbs_supervisor uut (.sys_clk(sys_clk), .rst(rst), .enable_pin(enable_pin),
    .sense_in(sense), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hs_gate(hs_gate), .ls_gate(ls_gate),
    .vref_target(vref_target), .flags(flags));

  tbs_companion comp (.sys_clk(sys_clk), .rst(rst), .go(go),
    .enable_pin(enable_pin), .vtrack(vtrack));

  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_state(output logic [3:0] st);
    logic [31:0] q;
    logic        e;
    apb(1'b0, ADDR_STATUS, 32'h0, q, e);
    st = q[7:4];
  endtask : rd_state

  task automatic wait_state(input logic [3:0] want, input int polls,
                            output logic [3:0] st);
    for (int i = 0; i < polls; i++)
    begin
      rd_state(st);
      if (st === want)
        break;
    end
  endtask : wait_state

  task automatic settle;
    repeat (8) @(posedge sys_clk);
  endtask : settle

  task automatic enable_cycle;
    go <= 1'b0;
    repeat (10) @(posedge sys_clk);
    go <= 1'b1;
    repeat (8) @(posedge sys_clk);
  endtask : enable_cycle

  task automatic count_hs(output int n);
    n = 0;
    repeat (128) @(posedge sys_clk) n += (hs_gate === 1'b1);
  endtask : count_hs

  // Gates never overlap, dead time after high side turns off
  always @(posedge sys_clk)
  begin
    hs_q <= hs_gate;
    if (!rst && (hs_gate & ls_gate)) chk(32'h1, 32'h0);
    if (!rst && hs_q && !hs_gate && ls_gate) chk(32'h1, 32'h0);
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [31:0] q;
    logic        e;
    apb(1'b0, ADDR_CTRL, 32'h0, q, e);
    chk(q, 32'h0000_0017);
    apb(1'b0, ADDR_THRESH, 32'h0, q, e);
    chk(q, 32'h007D_4B55);
    apb(1'b0, ADDR_OCP, 32'h0, q, e);
    chk(q, 32'h0000_005A);
    apb(1'b1, 12'h020, 32'hFFFF_FFFF, q, e);
    apb(1'b0, 12'h020, 32'h0, q, e);
    chk({q[30:0], e}, 32'h1);
    apb(1'b1, ADDR_THRESH, 32'h007D_4B20, q, e);
    apb(1'b0, ADDR_THRESH, 32'h0, q, e);
    chk(q, 32'h007D_4B3B);
    apb(1'b1, ADDR_THRESH, 32'h007D_4B70, q, e);
    apb(1'b0, ADDR_THRESH, 32'h0, q, e);
    chk(q, 32'h007D_4B64);
    apb(1'b1, ADDR_THRESH, 32'h007D_4B55, q, e);
    apb(1'b1, ADDR_CTRL, 32'h0000_001F, q, e);
    apb(1'b0, ADDR_CTRL, 32'h0, q, e);
    chk(q, 32'h0000_001F);
    apb(1'b1, ADDR_CTRL, 32'h0000_0010, q, e);
  endtask : t_regs

  task automatic t_start;
    logic [3:0] st;
    go <= 1'b1;
    repeat (40000) @(posedge sys_clk);
    rd_state(st);
    chk(32'(st), 32'(S_RAMP));
    vout <= 10'h100;
    wait_state(S_RUN, 5000, st);
    chk(32'(st), 32'(S_RUN));
    settle();
    chk(32'(vref_target), 32'h100);
    chk(32'(flags.pg), 32'h1);
  endtask : t_start

  task automatic t_ov;
    int n;
    vout <= 10'h0C8;
    settle();
    chk(32'({flags.pg, flags.uv}), 32'h0);
    vout <= 10'h14A;
    settle();
    chk(32'(flags.ov), 32'h1);
    count_hs(n);
    chk(32'(n), 32'h0);
    vout <= 10'h100;
    settle();
    chk(32'(flags.ov), 32'h0);
    count_hs(n);
    chk(32'(n != 0), 32'h1);
  endtask : t_ov

  task automatic t_oc_limit;
    logic [3:0]  st;
    logic [31:0] q;
    logic        e;
    int          n;
    iout <= 10'h082;
    settle();
    chk(32'(flags.oc), 32'h1);
    count_hs(n);
    chk(32'(n <= 8), 32'h1);
    rd_state(st);
    chk(32'(st), 32'(S_RUN));
    apb(1'b1, ADDR_OCP, 32'h0000_0064, q, e);
    settle();
    chk(32'(flags.oc), 32'h0);
    apb(1'b1, ADDR_OCP, 32'(OCP_DA_RST), q, e);
    iout <= 10'h000;
    settle();
    chk(32'(flags.oc), 32'h0);
  endtask : t_oc_limit

  task automatic t_uv;
    logic [3:0] st;
    vout <= 10'h096;
    settle();
    chk(32'(flags.uv), 32'h1);
    rd_state(st);
    chk(32'({st, flags.pg, hs_gate}), 32'(S_FAULT) << 2);
    vout <= 10'h100;
    settle();
    rd_state(st);
    chk(32'({st, flags.uv}), 32'(S_FAULT) << 1);
    enable_cycle();
    rd_state(st);
    chk(32'(st), 32'(S_RAMP));
  endtask : t_uv

  task automatic t_oc_trip;
    logic [3:0] st;
    iout <= 10'h096;
    settle();
    rd_state(st);
    chk(32'({st, flags.pg}), 32'(S_FAULT) << 1);
    iout <= 10'h000;
    settle();
    rd_state(st);
    chk(32'(st), 32'(S_FAULT));
    enable_cycle();
    rd_state(st);
    chk(32'(st), 32'(S_RAMP));
  endtask : t_oc_trip

  task automatic t_ot;
    logic [3:0] st;
    temp <= 8'h7C;
    settle();
    rd_state(st);
    chk(32'(st), 32'(S_RAMP));
    temp <= 8'h7D;
    settle();
    rd_state(st);
    chk(32'({st, flags.pg}), 32'(S_FAULT) << 1);
    enable_cycle();
    rd_state(st);
    chk(32'(st), 32'(S_FAULT));
    temp <= 8'h19;
    settle();
    enable_cycle();
    rd_state(st);
    chk(32'(st), 32'(S_RAMP));
    go <= 1'b0;
    settle();
    rd_state(st);
    chk(32'({st, vref_target}), 32'(S_OFF) << 10);
  endtask : t_ot

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("Mismatches %0d, comparisons %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  initial
  begin
    repeat (100000) @(posedge sys_clk);
    err_count++;
    print_verdict();
  end

  initial
  begin
    rst = 1'b1;
    go = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    vout = 10'h000;
    iout = 10'h000;
    temp = 8'h19;
    err_count = 0;
    n_compared = 0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_start();
    t_ov();
    t_oc_limit();
    t_uv();
    t_oc_trip();
    t_ot();
    print_verdict();
  end
endmodule : tb_tracking_buck_supervisor

// >>> tbs_companion.sv
/*
  Companion converter model: drives the shared enable and ramps the
  tracked rail up and down. Assumes the bench requests enable through go.
*/
`timescale 1ns/1ps
module tbs_companion
  import tbs_pkg::*;
#(
  parameter int unsigned STEP_CYC = 97,
  parameter logic [9:0]  RAIL_TOP = 10'h200
)
(
  input  wire logic  sys_clk,
  input  wire logic  rst,
  input  wire logic  go,
  output logic       enable_pin,
  output logic [9:0] vtrack
);
  int unsigned cnt;
  int unsigned sw_cnt;

  // Same signal enables both converters
  assign enable_pin = go;

  // Rail ramp over the same 1 ms soft-start, fast fall when disabled
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt    <= 0;
      sw_cnt <= 0;
      vtrack <= 10'h000;
    end
    else
    begin
      cnt    <= (cnt >= STEP_CYC - 1) ? 0 : cnt + 1;
      sw_cnt <= (sw_cnt >= PWM_PERIOD_CYC - 1) ? 0 : sw_cnt + 1;
      if (!go && vtrack != 10'h000 && sw_cnt == 0)
        vtrack <= vtrack - 10'h001;
      else if (go && vtrack != RAIL_TOP && cnt == 0)
        vtrack <= vtrack + 10'h001;
    end
  end
endmodule : tbs_companion

// >>> tbs_gate_drv.sv
/*
  Gate driver: turns a high-side request into complementary gate drives
  with dead time at every transition. Assumes request from same clock.
*/
`timescale 1ns/1ps
module tbs_gate_drv
  import tbs_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic run,
  input  wire logic hs_req,
  output logic      hs_gate,
  output logic      ls_gate
);

  logic [2:0] dead_r;
  logic       hs_r;
  logic       ls_r;

  // Break-before-make between the two switches
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      dead_r <= 3'h0;
      hs_r   <= 1'b0;
      ls_r   <= 1'b0;
    end
    else if (!run)
    begin
      dead_r <= 3'h0;
      hs_r   <= 1'b0;
      ls_r   <= 1'b0;
    end
    else if (hs_req != hs_r && (hs_r || ls_r))
    begin
      hs_r   <= 1'b0;
      ls_r   <= 1'b0;
      dead_r <= 3'(DEADTIME_CYC);
    end
    else if (dead_r != 3'h0)
      dead_r <= dead_r - 3'h1;
    else
    begin
      hs_r <= hs_req;
      ls_r <= !hs_req;
    end
  end

  assign hs_gate = hs_r;
  assign ls_gate = ls_r;

  no_overlap_a: assert property (@(posedge sys_clk) disable iff (rst)
    !(hs_gate && ls_gate)) else $error("gates overlap");

  dead_gap_a: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(hs_gate) && run |-> !ls_gate [*2]) else $error("no dead time");

endmodule : tbs_gate_drv

// >>> tbs_pkg.sv
/*
  Package for the tracking buck supervisor: APB register map, field positions,
  reset values, timing counts and the carrier structs.
  Assumes a 50 MHz system clock.
*/
package tbs_pkg;

  localparam int unsigned SYS_CLK_HZ     = 50_000_000;
  localparam int unsigned SS_UNIT_MS     = 1;
  localparam int unsigned CYC_PER_MS     = SYS_CLK_HZ / 1000 * SS_UNIT_MS;
  localparam int unsigned DEADTIME_NS    = 40;
  localparam int unsigned DEADTIME_CYC   = (DEADTIME_NS * 50 + 999) / 1000;
  localparam int unsigned PWM_PERIOD_CYC = 64;

  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_THRESH = 12'h004;
  localparam logic [11:0] ADDR_OCP    = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00C;
  localparam logic [11:0] ADDR_MEAS   = 12'h010;

  localparam int unsigned CTRL_SS_LSB   = 0;
  localparam int unsigned CTRL_OVE_BIT  = 4;
  localparam int unsigned TH_PG_LSB     = 0;
  localparam int unsigned TH_UV_LSB     = 8;
  localparam int unsigned TH_OV_LSB     = 16;
  localparam int unsigned OCP_SET_LSB   = 0;

  localparam logic [3:0]  SS_MS_RST     = 4'h7;
  localparam logic [6:0]  PG_PCT_RST    = 7'h55;
  localparam logic [6:0]  PG_PCT_MIN    = 7'h3B;
  localparam logic [6:0]  PG_PCT_MAX    = 7'h64;
  localparam logic [6:0]  UV_PCT_RST    = 7'h4B;
  localparam logic [7:0]  OV_PCT_RST    = 8'h7D;
  localparam logic [7:0]  OCP_DA_RST    = 8'h5A;
  localparam logic [7:0]  OCP_LIM_PCT   = 8'h8C;
  localparam logic [7:0]  OCP_TRIP_PCT  = 8'hA5;
  localparam logic [7:0]  OTP_DEG_C     = 8'h7D;
  localparam logic        OV_EN_RST     = 1'b1;

  typedef struct packed {
    logic [9:0] vout;
    logic [9:0] vtrack;
    logic [9:0] iout;
    logic [7:0] temp;
  } tbs_sense_s;

  typedef struct packed {
    logic pg;
    logic uv;
    logic ov;
    logic oc;
  } tbs_flags_s;

endpackage : tbs_pkg

// >>> tbs_supervisor.sv
/*
  Tracking buck supervisor: soft start that follows the tracked rail, hard
  stop on enable low, power good, fault flags, pulse skip and limit, latched shutdown.
  Assumes digitised sense values from other clock domains and an APB master.
*/
// Summary of operation
// - Output reference follows half the tracked rail
// - Soft-start time 1 to 16 ms, default 8
// - Undervoltage check held off until ramp ends
// - Power good above fraction, default 85%
// - Power good setting limited to 59..100%
// - Undervoltage flag below threshold, default 75%
// - Undervoltage stops switching, drops power good
// - Enable rising after clear restarts soft-start
// - Overvoltage flag above threshold, default 125%
// - Overvoltage skips high-side pulses while set
// - Above 140% current limit pulse, flag overcurrent
// - Above 165% current shut down, restart on enable
// - Overcurrent setting programmable, default 9 A
// - At or above 125 C shuts down, power good low
// - Temperature clear then enable rising restarts
// - Continuous conduction with dead time each cycle
`timescale 1ns/1ps
module tbs_supervisor
  import tbs_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        enable_pin,
  input  wire tbs_sense_s  sense_in,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             hs_gate,
  output logic             ls_gate,
  output logic [9:0]       vref_target,
  output tbs_flags_s       flags
);

  typedef enum logic [3:0] {
    ST_OFF   = 4'b0001,
    ST_RAMP  = 4'b0010,
    ST_RUN   = 4'b0100,
    ST_FAULT = 4'b1000
  } tbs_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic       en_m_r, en_s_r, en_d_r;
  tbs_sense_s sns_m_r, sns_r;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      en_m_r  <= 1'b0;
      en_s_r  <= 1'b0;
      en_d_r  <= 1'b0;
      sns_m_r <= '0;
      sns_r   <= '0;
    end
    else
    begin
      en_m_r  <= enable_pin;
      en_s_r  <= en_m_r;
      en_d_r  <= en_s_r;
      sns_m_r <= sense_in;
      sns_r   <= sns_m_r;
    end
  end

  logic en_rise;
  assign en_rise = en_s_r && !en_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [3:0] ss_ms_r;
  logic       ov_en_r;
  logic [6:0] pg_pct_r;
  logic [6:0] uv_pct_r;
  logic [7:0] ov_pct_r;
  logic [7:0] ocp_da_r;
  logic       wr_acc;

  function automatic logic [6:0] clamp_pg(input logic [6:0] v);
    if (v < PG_PCT_MIN)
      return PG_PCT_MIN;
    else if (v > PG_PCT_MAX)
      return PG_PCT_MAX;
    else
      return v;
  endfunction : clamp_pg

  assign wr_acc = psel && penable && pwrite;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ss_ms_r  <= SS_MS_RST;
      ov_en_r  <= OV_EN_RST;
      pg_pct_r <= PG_PCT_RST;
      uv_pct_r <= UV_PCT_RST;
      ov_pct_r <= OV_PCT_RST;
      ocp_da_r <= OCP_DA_RST;
    end
    else if (wr_acc)
    begin
      if (paddr == ADDR_CTRL)
      begin
        ss_ms_r <= pwdata[CTRL_SS_LSB +: 4];
        ov_en_r <= pwdata[CTRL_OVE_BIT];
      end
      if (paddr == ADDR_THRESH)
      begin
        pg_pct_r <= clamp_pg(pwdata[TH_PG_LSB +: 7]);
        uv_pct_r <= pwdata[TH_UV_LSB +: 7];
        ov_pct_r <= pwdata[TH_OV_LSB +: 8];
      end
      if (paddr == ADDR_OCP)
        ocp_da_r <= pwdata[OCP_SET_LSB +: 8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Thresholds: voltages relative to the tracked target, current to the OCP setting, temperature fixed
  logic [9:0]  target;
  logic [16:0] vout_x100;
  logic [16:0] trk_x_pg, trk_x_uv;
  logic [17:0] trk_x_ov;
  logic [16:0] i_x1000;
  logic [17:0] set_x_lim, set_x_trip;

  assign target     = {1'b0, sns_r.vtrack[9:1]};
  assign vout_x100  = 17'(sns_r.vout) * 17'h64;
  assign trk_x_pg   = 17'(target) * 17'(pg_pct_r);
  assign trk_x_uv   = 17'(target) * 17'(uv_pct_r);
  assign trk_x_ov   = 18'(target) * 18'(ov_pct_r);
  assign i_x1000    = 17'(sns_r.iout) * 17'h64;
  assign set_x_lim  = 18'(ocp_da_r) * 18'(OCP_LIM_PCT);
  assign set_x_trip = 18'(ocp_da_r) * 18'(OCP_TRIP_PCT);

  logic uv_lvl, ov_lvl, oc_lim, oc_trip, ot_lvl, pg_lvl;
  assign pg_lvl  = vout_x100 > trk_x_pg;
  assign uv_lvl  = vout_x100 < trk_x_uv;
  assign ov_lvl  = ov_en_r && (18'(vout_x100) > trk_x_ov);
  assign oc_lim  = 18'(i_x1000) > set_x_lim;
  assign oc_trip = 18'(i_x1000) > set_x_trip;
  assign ot_lvl  = sns_r.temp >= OTP_DEG_C;

  ////////////////////////////////////////////////////////////////////////////
  // Supervisor state machine
  tbs_state_e state_r;
  logic [19:0] ss_cnt_r;
  logic [19:0] ss_cyc;
  logic        uv_armed;
  logic        shut_fault;
  logic        fault_clear;

  assign ss_cyc      = 20'(CYC_PER_MS) * (20'(ss_ms_r) + 20'h1);
  assign uv_armed    = (state_r == ST_RUN);
  assign shut_fault  = (uv_armed && uv_lvl) || oc_trip || ot_lvl;
  assign fault_clear = !uv_lvl && !ot_lvl && !oc_trip;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      state_r <= ST_OFF;
    else
    begin
      unique case (state_r)
        ST_OFF:
          if (en_rise && fault_clear)
            state_r <= ST_RAMP;
        ST_RAMP:
          if (oc_trip || ot_lvl)
            state_r <= ST_FAULT;
          else if (!en_s_r)
            state_r <= ST_OFF;
          else if (ss_cnt_r >= ss_cyc)
            state_r <= ST_RUN;
        ST_RUN:
          if (shut_fault)
            state_r <= ST_FAULT;
          else if (!en_s_r)
            state_r <= ST_OFF;
        ST_FAULT:
          if (en_rise && fault_clear)
            state_r <= ST_RAMP;
        default:
          state_r <= ST_OFF;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      ss_cnt_r <= 20'h0;
    else if (state_r != ST_RAMP)
      ss_cnt_r <= 20'h0;
    else if (ss_cnt_r < ss_cyc)
      ss_cnt_r <= ss_cnt_r + 20'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // PWM with pulse skip and cycle limit
  logic [5:0] pwm_cnt_r;
  logic [5:0] duty;
  logic       hs_req;
  logic       running;

  assign running = (state_r == ST_RAMP) || (state_r == ST_RUN);
  assign duty    = sns_r.vtrack[9:4] >> 1;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      pwm_cnt_r <= 6'h0;
    else
      pwm_cnt_r <= pwm_cnt_r + 6'h1;
  end

  // Current limit ends the pulse for the rest of the cycle
  logic lim_r;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      lim_r <= 1'b0;
    else if (pwm_cnt_r == 6'h0)
      lim_r <= oc_lim;
    else if (oc_lim)
      lim_r <= 1'b1;
  end

  assign hs_req = running && (pwm_cnt_r < duty) && !ov_lvl && !lim_r;

  tbs_gate_drv u_drv (
    .sys_clk (sys_clk),
    .rst     (rst),
    .run     (running),
    .hs_req  (hs_req),
    .hs_gate (hs_gate),
    .ls_gate (ls_gate)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  tbs_flags_s flags_r;
  logic [9:0] vref_r;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      flags_r <= '0;
      vref_r  <= 10'h0;
    end
    else
    begin
      flags_r.pg <= running && pg_lvl;
      flags_r.uv <= uv_lvl;
      flags_r.ov <= ov_lvl;
      flags_r.oc <= oc_lim;
      vref_r     <= running ? target : 10'h0;
    end
  end

  assign flags       = flags_r;
  assign vref_target = vref_r;

  ////////////////////////////////////////////////////////////////////////////
  // APB read path, zero wait states
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        ADDR_CTRL:   prdata <= {27'h0, ov_en_r, ss_ms_r};
        ADDR_THRESH: prdata <= {8'h0, ov_pct_r, 1'b0, uv_pct_r, 1'b0, pg_pct_r};
        ADDR_OCP:    prdata <= {24'h0, ocp_da_r};
        ADDR_STATUS: prdata <= {24'h0, state_r, flags_r};
        ADDR_MEAS:   prdata <= {2'h0, sns_r.iout, sns_r.vtrack, sns_r.vout};
        default:     prdata <= 32'h0;
      endcase
    end
  end

  logic addr_ok;
  assign addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_THRESH) ||
                   (paddr == ADDR_OCP) || (paddr == ADDR_STATUS) ||
                   (paddr == ADDR_MEAS);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  uv_holdoff_a: assert property (@(posedge sys_clk) disable iff (rst)
    state_r == ST_RAMP |=> state_r != ST_FAULT || oc_trip || ot_lvl
      || $past(oc_trip) || $past(ot_lvl))
    else $error("undervoltage acted during ramp");

  uv_shutdown_a: assert property (@(posedge sys_clk) disable iff (rst)
    state_r == ST_RUN && uv_lvl |=> state_r == ST_FAULT ##1 !flags.pg)
    else $error("undervoltage did not shut down");

  fault_latch_a: assert property (@(posedge sys_clk) disable iff (rst)
    state_r == ST_FAULT && !en_rise |=> state_r == ST_FAULT)
    else $error("fault released without enable");

  restart_a: assert property (@(posedge sys_clk) disable iff (rst)
    state_r == ST_FAULT && en_rise && fault_clear |=> state_r == ST_RAMP)
    else $error("no restart on enable");

  ov_skip_a: assert property (@(posedge sys_clk) disable iff (rst)
    ov_lvl |=> !hs_gate) else $error("pulse during overvoltage");

  oc_trip_a: assert property (@(posedge sys_clk) disable iff (rst)
    oc_trip && running |=> state_r == ST_FAULT ##1 !flags.pg)
    else $error("overcurrent trip ignored");

  ot_trip_a: assert property (@(posedge sys_clk) disable iff (rst)
    ot_lvl && running |=> state_r == ST_FAULT)
    else $error("overtemperature ignored");

  pg_range_a: assert property (@(posedge sys_clk) disable iff (rst)
    pg_pct_r >= PG_PCT_MIN && pg_pct_r <= PG_PCT_MAX)
    else $error("power good setting out of range");

  uv_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
    uv_lvl |=> flags.uv) else $error("undervoltage flag missing");

  oc_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
    oc_lim |=> flags.oc) else $error("overcurrent flag missing");

endmodule : tbs_supervisor
